// [rtl/setpoint_pkg.sv]
/*
 Constants, register map and carrier types for the converter setpoint
 register pair. Assumes a register port that delivers decoded
 write/read strobes with an 8-bit subaddress, on the 125 MHz clock.
*/
// How it works
// - Buck3 register at 0x18, resets 0xBD
// - Writes land only while password unlocked
// - Buck3 write blanks its supervision 5 ms
// - Bit 7 pulse-skip enable, resets to one
// - Buck3 bits 5:0 setpoint, reset 3Dh
// - Buck3 code steps 25 mV, then 50 mV
// - Buckboost4 register at 0x19, resets 0x94
// - Buckboost4 write blanks its supervision 5 ms
// - Resistor select may supply alternate defaults
// - Buckboost4 bits 5:0 setpoint, reset 14h
package setpoint_pkg;
	localparam logic [7:0]  BUCK3_ADDR       = 8'h18;
	localparam logic [7:0]  BUCKBOOST4_ADDR  = 8'h19;
	localparam logic [7:0]  BUCK3_RESET      = 8'hBD;
	localparam logic [7:0]  BUCKBOOST4_RESET = 8'h94;
	localparam int          SKIP_BIT         = 7;
	localparam int          RSVD_BIT         = 6;
	localparam int          SET_MSB          = 5;
	localparam logic [5:0]  BUCK3_FINE_LAST  = 6'h1A;
	localparam logic [5:0]  BB4_LAST_CODE    = 6'h34;
	localparam logic [15:0] BUCK3_BASE_MV    = 16'h0384;
	localparam logic [15:0] BUCK3_KNEE_MV    = 16'h0640;
	localparam logic [15:0] FINE_STEP_MV     = 16'h0019;
	localparam logic [15:0] COARSE_STEP_MV   = 16'h0032;
	localparam int          CLOCK_MHZ        = 125;
	localparam int          BLANK_TIME_MS    = 5;
	localparam int          BLANK_CYCLES     = BLANK_TIME_MS * 1000 * CLOCK_MHZ;
	localparam int          BLANK_WIDTH      = 20;
	localparam logic [1:0]  STRAP_SETTLE     = 2'h2;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic       pulse_skip_enable;
		logic [5:0] setpoint;
	} conv_cfg_s;
endpackage

// [rtl/converter_setpoint_regs.sv]
/*
 Setpoint register pair for the third buck and the buck-boost converter.
 Assumes the serial register port has already decoded a transaction into
 a one-cycle request on this clock, and the password logic supplies a
 synchronous unlock level. Supervisor blanking is driven out per converter.
*/
`timescale 1ns/10ps
`default_nettype none
module converter_setpoint_regs
	import setpoint_pkg::*;
#(
	parameter int BLANK_COUNT = BLANK_CYCLES                // Blanking length in cycles
) (
	input  wire logic      clock,                         // 125 MHz clock
	input  wire logic      arst_n,                        // Async reset, active low
	input  wire reg_req_s  req,                           // Register port request
	input  wire logic      write_unlocked,                // Password permits writes
	input  wire logic      default_select_resistor,       // Strap: use alternate default
	input  wire logic [7:0] buck3_alt_default,            // Alternate buck3 default
	input  wire logic [7:0] buckboost4_alt_default,       // Alternate buckboost4 default
	output logic [7:0]     rdata_q,                       // Read data
	output logic           rvalid_q,                      // Read data valid pulse
	output var conv_cfg_s  buck3_cfg_q,                   // Buck3 config to converter
	output var conv_cfg_s  buckboost4_cfg_q,              // Buckboost4 config
	output logic [15:0]    buck3_target_mv_q,             // Buck3 target in mV
	output logic           buck3_blank_q,                 // Buck3 supervisor blanked
	output logic           buckboost4_blank_q             // Buckboost4 supervisor blanked
);
	logic        strap_meta_q;
	logic        strap_sync_q;
	logic [1:0]  strap_age_q;
	logic        strap_wr_seen_q;
	logic        strap_apply;
	logic        wr_b3;
	logic        wr_b4;
	logic [15:0] target_d;

	// Write strobes gated by the password unlock
	assign wr_b3 = req.wr && write_unlocked && (req.addr == BUCK3_ADDR);
	assign wr_b4 = req.wr && write_unlocked && (req.addr == BUCKBOOST4_ADDR);

	// Strap from a pin, two flops before use
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
		end else begin
			strap_meta_q <= default_select_resistor;
			strap_sync_q <= strap_meta_q;
		end
	end

	// Edges since reset release, saturating once the strap window is over.
	// The synchroniser needs two edges before its output means anything,
	// so the strap is only looked at once this count reaches the settle value.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_age_q <= 2'h0;
		end else if (strap_age_q != 2'h3) begin
			strap_age_q <= strap_age_q + 2'h1;
		end
	end

	// Any landed write closes the strap window for good.
	// Without this a host write in the first edges would be undone
	// by the late strap load, which would look like a lost write.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_wr_seen_q <= 1'b0;
		end else if (wr_b3 || wr_b4) begin
			strap_wr_seen_q <= 1'b1;
		end
	end

	// Single-cycle load of the alternate defaults
	// Limitation: the strap is read once; later pin changes are ignored
	// until the next reset, as a power-up default should behave.
	assign strap_apply = (strap_age_q == STRAP_SETTLE) && strap_sync_q
		&& !strap_wr_seen_q;

	// Buck3 register; bit 6 has no storage so reads stay zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			buck3_cfg_q.pulse_skip_enable <= BUCK3_RESET[SKIP_BIT];
			buck3_cfg_q.setpoint          <= BUCK3_RESET[SET_MSB:0];
		end else if (wr_b3) begin
			buck3_cfg_q.pulse_skip_enable <= req.wdata[SKIP_BIT];
			buck3_cfg_q.setpoint          <= req.wdata[SET_MSB:0];
		end else if (strap_apply) begin
			// Strap loads only while no write has landed; a same-cycle write wins
			buck3_cfg_q.pulse_skip_enable <= buck3_alt_default[SKIP_BIT];
			buck3_cfg_q.setpoint          <= buck3_alt_default[SET_MSB:0];
		end
	end

	// Buckboost4 register; reserved codes are the host's to avoid
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			buckboost4_cfg_q.pulse_skip_enable <= BUCKBOOST4_RESET[SKIP_BIT];
			buckboost4_cfg_q.setpoint          <= BUCKBOOST4_RESET[SET_MSB:0];
		end else if (wr_b4) begin
			buckboost4_cfg_q.pulse_skip_enable <= req.wdata[SKIP_BIT];
			buckboost4_cfg_q.setpoint          <= req.wdata[SET_MSB:0];
		end else if (strap_apply) begin
			buckboost4_cfg_q.pulse_skip_enable <= buckboost4_alt_default[SKIP_BIT];
			buckboost4_cfg_q.setpoint          <= buckboost4_alt_default[SET_MSB:0];
		end
	end

	// Read path; unmapped subaddresses read zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req.rd;
			if (req.rd) begin
				case (req.addr)
					BUCK3_ADDR:      rdata_q <= {buck3_cfg_q.pulse_skip_enable, 1'b0,
						buck3_cfg_q.setpoint};
					BUCKBOOST4_ADDR: rdata_q <= {buckboost4_cfg_q.pulse_skip_enable, 1'b0,
						buckboost4_cfg_q.setpoint};
					default:         rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// Buck3 code to millivolts: fine range then coarse range
	always_comb begin
		if (buck3_cfg_q.setpoint <= BUCK3_FINE_LAST) begin
			target_d = BUCK3_BASE_MV + 16'(buck3_cfg_q.setpoint) * FINE_STEP_MV;
		end else begin
			target_d = BUCK3_KNEE_MV
				+ 16'(buck3_cfg_q.setpoint - BUCK3_FINE_LAST - 6'h01) * COARSE_STEP_MV;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			buck3_target_mv_q <= 16'h0000;
		end else begin
			buck3_target_mv_q <= target_d;
		end
	end

	// Blanking timer for the buck3 supervisor
	// Only landed writes count; a locked write changes nothing,
	// so it has no reason to blind the supervisor.
	blank_timer #(
		.COUNT   (BLANK_COUNT)
	) u_buck3_blank (
		.clock   (clock),
		.arst_n  (arst_n),
		.restart (wr_b3),
		.blank_q (buck3_blank_q)
	);

	// Blanking timer for the buckboost4 supervisor
	blank_timer #(
		.COUNT   (BLANK_COUNT)
	) u_buckboost4_blank (
		.clock   (clock),
		.arst_n  (arst_n),
		.restart (wr_b4),
		.blank_q (buckboost4_blank_q)
	);
endmodule

// Supervisor blanking interval, one instance per converter.
// A restart during a running interval reloads the full length,
// so the supervisor never wakes up in the middle of a new ramp.
// The flag is registered so the converter side sees a clean level.
module blank_timer
	import setpoint_pkg::*;
#(
	parameter int COUNT = BLANK_CYCLES                  // Interval length in cycles
) (
	input  wire logic clock,                            // 125 MHz clock
	input  wire logic arst_n,                           // Async reset, active low
	input  wire logic restart,                          // A write landed
	output logic      blank_q                           // Supervision blanked
);
	localparam logic [BLANK_WIDTH-1:0] LOAD = BLANK_WIDTH'(COUNT);

	logic [BLANK_WIDTH-1:0] cnt_q;

	// Down counter; blank stays high for exactly the load count in cycles
	// Trade-off: a shared counter would save flops but couple the converters
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q   <= '0;
			blank_q <= 1'b0;
		end else begin
			if (restart) begin
				cnt_q <= LOAD;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
			blank_q <= restart || (cnt_q > BLANK_WIDTH'(1));
		end
	end
endmodule
`default_nettype wire

// [bench/setpoint_properties.sv]
/* Port-level checker for the setpoint register pair.
 Assumes it is bound onto converter_setpoint_regs. */
`timescale 1ns/10ps
`default_nettype none
module setpoint_properties
	import setpoint_pkg::*;
#(
	parameter int BLANK_COUNT = 20 // Blanking length in cycles
) (
	input wire logic        clock,              // Clock
	input wire logic        arst_n,             // Reset, active low
	input wire reg_req_s    req,                // Register request
	input wire logic        write_unlocked,     // Writes permitted
	input wire logic [7:0]  rdata_q,            // Read data
	input wire logic        rvalid_q,           // Read valid
	input wire conv_cfg_s   buck3_cfg_q,        // Buck3 config
	input wire conv_cfg_s   buckboost4_cfg_q,   // Buckboost4 config
	input wire logic [15:0] buck3_target_mv_q,  // Buck3 target
	input wire logic        buck3_blank_q,      // Buck3 blank
	input wire logic        buckboost4_blank_q  // Buckboost4 blank
);
	logic [7:0]  wd_q;
	logic [15:0] exp_mv;
	logic        wr_ok;
	// Write data delayed to line up with the register update
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n) wd_q <= 8'h00;
		else wd_q <= req.wdata;
	// Two slopes, the knee sits after the last fine code
	assign exp_mv = (buck3_cfg_q.setpoint <= BUCK3_FINE_LAST)
		? BUCK3_BASE_MV + FINE_STEP_MV * buck3_cfg_q.setpoint
		: BUCK3_KNEE_MV + COARSE_STEP_MV * (buck3_cfg_q.setpoint - 6'h1B);
	assign wr_ok = req.wr && write_unlocked;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_locked_write_ignored: assert property (req.wr && !write_unlocked && !$past(wr_ok)
		|=> $stable(buck3_cfg_q) && $stable(buckboost4_cfg_q)) else $error("locked write landed");
	a_buck3_write_lands: assert property (wr_ok && req.addr == BUCK3_ADDR
		|=> buck3_cfg_q == {wd_q[7], wd_q[5:0]}) else $error("buck3 write wrong");
	a_bb4_write_lands: assert property (wr_ok && req.addr == BUCKBOOST4_ADDR
		|=> buckboost4_cfg_q == {wd_q[7], wd_q[5:0]}) else $error("buckboost4 write wrong");
	a_buck3_blank_hold: assert property (wr_ok && req.addr == BUCK3_ADDR
		|=> buck3_blank_q [*8]) else $error("buck3 blank short");
	a_bb4_blank_rise: assert property (wr_ok && req.addr == BUCKBOOST4_ADDR
		|=> buckboost4_blank_q) else $error("buckboost4 blank missing");
	a_read_rsvd_zero: assert property (req.rd |=> rvalid_q && !rdata_q[RSVD_BIT])
		else $error("read answer wrong");
	a_unmapped_read_zero: assert property (req.rd && req.addr != BUCK3_ADDR
		&& req.addr != BUCKBOOST4_ADDR |=> rdata_q == 8'h00) else $error("unmapped read");
	a_target_map: assert property ($past(arst_n) |-> buck3_target_mv_q == $past(exp_mv))
		else $error("buck3 target wrong");
endmodule
`default_nettype wire

// [bench/host_model.sv]
/* Host side of the register port: single register accesses.
 Assumes the bench drives the unlock level; a write while locked is ignored. */
`timescale 1ns/10ps
`default_nettype none
module host_model
	import setpoint_pkg::*;
(
	input  wire logic clock, // Clock
	output var reg_req_s req // Request to the device
);
	initial req = '0;
	// One-cycle request; the caller never picks reserved buckboost4 codes
	// nor touches a running converter
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		req <= reg_req_s'{w, !w, a, d};
		@(negedge clock);
		req <= '0;
	endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
/* Self-checking bench for the setpoint register pair.
 Assumes the host model and a shortened blanking count. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import setpoint_pkg::*;
	localparam int BLANK = 20;
	logic clock = 0, arst_n = 0, unl = 0, strap = 0, rvalid, b3, b4;
	logic [7:0] rdata;
	logic [15:0] mv;
	reg_req_s req;
	conv_cfg_s c3, c4;
	int error_cnt = 0, checks_done = 0;
	always #4 clock = ~clock;
	host_model u_host_model(.clock(clock), .req(req));
	converter_setpoint_regs #(.BLANK_COUNT(BLANK)) u_converter_setpoint_regs(.clock(clock),
		.arst_n(arst_n), .req(req), .write_unlocked(unl), .default_select_resistor(strap),
		.buck3_alt_default(8'h85), .buckboost4_alt_default(8'h8A), .rdata_q(rdata),
		.rvalid_q(rvalid), .buck3_cfg_q(c3), .buckboost4_cfg_q(c4), .buck3_target_mv_q(mv),
		.buck3_blank_q(b3), .buckboost4_blank_q(b4));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_host_model.access(1'b0, a, 8'h00);
		chk(rvalid, 16'h0001);
		chk(rdata, exp);
	endtask
	task automatic test_done;
		if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Codes on both sides of the knee and the ends of the range
	task automatic t_codes;
		logic [7:0] wv[4] = '{8'hFF, 8'h1A, 8'h1B, 8'h00};
		logic [15:0] mvv[4] = '{16'h0D48, 16'h060E, 16'h0640, 16'h0384};
		for (int i = 0; i < 4; i++) begin
			u_host_model.access(1'b1, BUCK3_ADDR, wv[i]);
			chk(b3, 16'h0001);
			rd_chk(BUCK3_ADDR, wv[i] & 8'hBF);
			chk(mv, mvv[i]);
		end
	endtask
	// Blank length and the reserved bit on the second register
	task automatic t_blank;
		u_host_model.access(1'b1, BUCKBOOST4_ADDR, 8'h74);
		chk(b4, 16'h0001);
		repeat (BLANK - 1) @(negedge clock);
		chk(b4, 16'h0001);
		@(negedge clock);
		chk(b4, 16'h0000);
		rd_chk(BUCKBOOST4_ADDR, 8'h34);
	endtask
	// Strap high across a second reset selects the alternate defaults
	task automatic t_strap;
		strap = 1;
		arst_n = 0;
		repeat (2) @(negedge clock);
		arst_n = 1;
		repeat (4) @(negedge clock);
		rd_chk(BUCK3_ADDR, 8'h85);
		rd_chk(BUCKBOOST4_ADDR, 8'h8A);
		chk(mv, 16'h0401);
		chk(b3, 16'h0000);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		arst_n = 1;
		rd_chk(BUCK3_ADDR, BUCK3_RESET);
		rd_chk(BUCKBOOST4_ADDR, BUCKBOOST4_RESET);
		chk(mv, 16'h0CE4);
		u_host_model.access(1'b1, BUCK3_ADDR, 8'h00);
		rd_chk(BUCK3_ADDR, BUCK3_RESET);
		unl = 1;
		t_codes();
		t_blank();
		rd_chk(8'h20, 8'h00);
		t_strap();
		test_done();
	end
	// Watchdog well past the expected run
	initial begin
		#24000;
		error_cnt++;
		test_done();
	end
endmodule
bind converter_setpoint_regs setpoint_properties #(.BLANK_COUNT(BLANK_COUNT)) u_setpoint_properties(
	.clock(clock), .arst_n(arst_n), .req(req), .write_unlocked(write_unlocked),
	.rdata_q(rdata_q), .rvalid_q(rvalid_q), .buck3_cfg_q(buck3_cfg_q),
	.buckboost4_cfg_q(buckboost4_cfg_q), .buck3_target_mv_q(buck3_target_mv_q),
	.buck3_blank_q(buck3_blank_q), .buckboost4_blank_q(buckboost4_blank_q));
`default_nettype wire
